// [src/pdcer_regs.sv]
`include "pdcer_defs.svh"

module pdcer_regs
  import pdcer_pkg::*;
(
  input  wire logic        clock_i,           // Control-port clock
  input  wire logic        reset_n_i,         // Sync reset, active low
  input  wire logic        clk_en_i,          // Freezes state when low
  input  wire logic [7:0]  reg_addr_i,        // Register address
  input  wire logic        reg_wr_i,          // Write strobe
  input  wire logic [7:0]  reg_wdata_i,       // Write data
  input  wire logic        reg_rd_i,          // Read strobe
  input  wire pdcer_vols_t vol_i,             // Per-channel volume settings
  output logic [7:0]       reg_rdata_o,       // Read data
  output logic             reg_rvalid_o,      // Read data valid pulse
  output pdcer_path_s      path_cfg_o,        // Playback path fields
  output pdcer_chan_s      chan_en_o,         // Channel enables
  output logic [2:0]       biquad_stage_en_o, // Per-stage biquad enables
  output logic             soft_step_on_o,    // Soft-step volume changes
  output logic             resp_reserved_o,   // Reserved response code held
  output pdcer_vols_t      vol_o,             // Volume applied per channel
  output logic [1:4]       vol_valid_o        // Channel active and volume applied
);

  pdcer_path_s path_ff;
  pdcer_path_s nxt_path;
  pdcer_chan_s chan_ff;
  pdcer_chan_s nxt_chan;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [2:0]  bq_en_ff;
  logic [2:0]  nxt_bq_en;
  logic        soft_on_ff;
  logic        nxt_soft_on;
  logic        rsvd_ff;
  logic        nxt_rsvd;
  logic        wr_path;
  logic        wr_chan;

  // Reset images; the decoded copies are seeded from the same value
  localparam pdcer_path_s RST_PATH = pdcer_path_s'(`PDCER_RST_PATH_CFG);
  localparam pdcer_chan_s RST_CHAN = pdcer_chan_s'(`PDCER_RST_CHAN_EN);

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  assign wr_path = reg_wr_i && addr_is(reg_addr_i, `PDCER_ADDR_PATH_CFG);
  assign wr_chan = reg_wr_i && addr_is(reg_addr_i, `PDCER_ADDR_CHAN_EN);

  // Register contents and their decoded copies
  always_comb begin
    nxt_path = path_ff;
    nxt_chan = chan_ff;
    if (wr_path) begin
      nxt_path.response      = pdcer_resp_e'(reg_wdata_i[`PDCER_RESP_MSB:`PDCER_RESP_LSB]);
      nxt_path.highpass      = pdcer_hpf_e'(reg_wdata_i[`PDCER_HPF_MSB:`PDCER_HPF_LSB]);
      nxt_path.biquads       = reg_wdata_i[`PDCER_BQ_MSB:`PDCER_BQ_LSB];
      nxt_path.soft_step_off = reg_wdata_i[`PDCER_SOFT_OFF_BIT];
      nxt_path.volume_shared = reg_wdata_i[`PDCER_GANG_BIT];
    end
    if (wr_chan) begin
      nxt_chan.record_on   = reg_wdata_i[`PDCER_REC_MSB:`PDCER_REC_LSB];
      nxt_chan.playback_on = reg_wdata_i[`PDCER_PLAY_MSB:`PDCER_PLAY_LSB];
    end
    nxt_bq_en   = pdcer_bq_stages(nxt_path.biquads);
    nxt_soft_on = !nxt_path.soft_step_off;
    // Reserved code is stored as written; flagged for the filter logic
    nxt_rsvd    = (nxt_path.response == PDCER_RESP_RSVD);
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      path_ff    <= RST_PATH;
      chan_ff    <= RST_CHAN;
      bq_en_ff   <= pdcer_bq_stages(RST_PATH.biquads);
      soft_on_ff <= !RST_PATH.soft_step_off;
      rsvd_ff    <= (RST_PATH.response == PDCER_RESP_RSVD);
    end else if (clk_en_i) begin
      path_ff    <= nxt_path;
      chan_ff    <= nxt_chan;
      bq_en_ff   <= nxt_bq_en;
      soft_on_ff <= nxt_soft_on;
      rsvd_ff    <= nxt_rsvd;
    end
  end

  // Read port; unmapped addresses read zero
  always_comb begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = reg_rd_i;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `PDCER_ADDR_PATH_CFG: nxt_rdata = path_ff;
        `PDCER_ADDR_CHAN_EN:  nxt_rdata = chan_ff;
        default:              nxt_rdata = `PDCER_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rdata_ff  <= `PDCER_RDATA_IDLE;
      rvalid_ff <= 1'b0;
    end else if (clk_en_i) begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  pdcer_vol_route u_vol_route (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .clk_en_i    (clk_en_i),
    .shared_i    (path_ff.volume_shared),
    .active_i    (chan_ff.playback_on),
    .vol_i       (vol_i),
    .vol_o       (vol_o),
    .vol_valid_o (vol_valid_o)
  );

  assign reg_rdata_o       = rdata_ff;
  assign reg_rvalid_o      = rvalid_ff;
  assign path_cfg_o        = path_ff;
  assign chan_en_o         = chan_ff;
  assign biquad_stage_en_o = bq_en_ff;
  assign soft_step_on_o    = soft_on_ff;
  assign resp_reserved_o   = rsvd_ff;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_path_reset: assert property (disable iff (1'b0)
    !reset_n_i |=> path_cfg_o == pdcer_path_s'(`PDCER_RST_PATH_CFG) && biquad_stage_en_o == 3'h3)
    else $error("Path config reset value wrong");

  chk_chan_reset: assert property (disable iff (1'b0)
    !reset_n_i |=> chan_en_o == pdcer_chan_s'(`PDCER_RST_CHAN_EN))
    else $error("Channel enable reset value wrong");

  chk_path_write: assert property (
    reset_n_i && clk_en_i && reg_wr_i && reg_addr_i == `PDCER_ADDR_PATH_CFG
      |=> path_cfg_o == $past(reg_wdata_i))
    else $error("Path config write not stored");

  chk_chan_write: assert property (
    reset_n_i && clk_en_i && reg_wr_i && reg_addr_i == `PDCER_ADDR_CHAN_EN
      |=> chan_en_o.record_on == $past(reg_wdata_i[7:4])
          && chan_en_o.playback_on == $past(reg_wdata_i[3:0]))
    else $error("Channel enable write not stored");

  chk_path_hold: assert property (
    reset_n_i && !(clk_en_i && reg_wr_i && reg_addr_i == `PDCER_ADDR_PATH_CFG)
      |=> $stable(path_cfg_o))
    else $error("Path config changed without a write");

  chk_chan_hold: assert property (
    reset_n_i && !(clk_en_i && reg_wr_i && reg_addr_i == `PDCER_ADDR_CHAN_EN)
      |=> $stable(chan_en_o))
    else $error("Channel enables changed without a write");

  chk_stage_decode: assert property (
    $countones(biquad_stage_en_o) == path_cfg_o.biquads && soft_step_on_o == !path_cfg_o.soft_step_off)
    else $error("Decoded stage or soft-step output wrong");

  chk_read_back: assert property (
    reset_n_i && clk_en_i && reg_rd_i && reg_addr_i == `PDCER_ADDR_PATH_CFG
      |=> reg_rvalid_o && reg_rdata_o == $past(path_cfg_o))
    else $error("Path config read-back wrong");

  chk_rsvd_flag: assert property (
    resp_reserved_o == (path_cfg_o.response == PDCER_RESP_RSVD))
    else $error("Reserved response flag wrong");

  chk_read_chan: assert property (
    reset_n_i && clk_en_i && reg_rd_i && reg_addr_i == `PDCER_ADDR_CHAN_EN
      |=> reg_rvalid_o && reg_rdata_o == $past(chan_en_o))
    else $error("Channel enable read-back wrong");

  chk_read_other: assert property (
    reset_n_i && clk_en_i && reg_rd_i && reg_addr_i != `PDCER_ADDR_PATH_CFG
      && reg_addr_i != `PDCER_ADDR_CHAN_EN
      |=> reg_rvalid_o && reg_rdata_o == `PDCER_RDATA_IDLE)
    else $error("Unmapped address did not read zero");

  chk_rvalid_pulse: assert property (
    reset_n_i && clk_en_i |=> reg_rvalid_o == $past(reg_rd_i))
    else $error("Read valid is not a one-cycle answer");

  chk_rdata_hold: assert property (
    reset_n_i && !(clk_en_i && reg_rd_i) |=> $stable(reg_rdata_o))
    else $error("Read data changed without a read");

  chk_frozen_state: assert property (
    reset_n_i && !clk_en_i |=> $stable(reg_rvalid_o) && $stable(biquad_stage_en_o)
      && $stable(vol_o) && $stable(vol_valid_o))
    else $error("State moved while the clock enable was low");

  chk_reset_outs: assert property (disable iff (1'b0)
    !reset_n_i |=> reg_rdata_o == `PDCER_RDATA_IDLE && !reg_rvalid_o && !resp_reserved_o
      && soft_step_on_o && vol_o == '0 && vol_valid_o == '0)
    else $error("Output reset value wrong");

  chk_hpf_field: assert property (
    reset_n_i && clk_en_i && wr_path
      |=> path_cfg_o.highpass == $past(reg_wdata_i[`PDCER_HPF_MSB:`PDCER_HPF_LSB]))
    else $error("High-pass select not stored");

  chk_count_field: assert property (
    reset_n_i && clk_en_i && wr_path
      |=> path_cfg_o.biquads == $past(reg_wdata_i[`PDCER_BQ_MSB:`PDCER_BQ_LSB]))
    else $error("Biquad count not stored");

  chk_soft_field: assert property (
    reset_n_i && clk_en_i && wr_path
      |=> soft_step_on_o == !$past(reg_wdata_i[`PDCER_SOFT_OFF_BIT]))
    else $error("Soft-step control not applied");

  chk_gang_field: assert property (
    reset_n_i && clk_en_i && wr_path
      |=> path_cfg_o.volume_shared == $past(reg_wdata_i[`PDCER_GANG_BIT]))
    else $error("Volume sharing bit not stored");

  cov_gang_on: cover property (clk_en_i && wr_path && reg_wdata_i[`PDCER_GANG_BIT]);
  cov_hpf_fixed: cover property (path_cfg_o.highpass == PDCER_HPF_FS_2M);
  cov_chan_read: cover property (reg_rvalid_o && reg_rdata_o == 8'hff);
  cov_rsvd_code: cover property (resp_reserved_o);
  cov_frozen_wr: cover property (!clk_en_i && reg_wr_i);

endmodule

// [src/pdcer_defs.svh]
`ifndef PDCER_DEFS_SVH
`define PDCER_DEFS_SVH

`define PDCER_ADDR_PATH_CFG 8'h73
`define PDCER_ADDR_CHAN_EN  8'h76
`define PDCER_RST_PATH_CFG  8'h18
`define PDCER_RST_CHAN_EN   8'hcc
`define PDCER_RDATA_IDLE    8'h00

`define PDCER_RESP_MSB      7
`define PDCER_RESP_LSB      6
`define PDCER_HPF_MSB       5
`define PDCER_HPF_LSB       4
`define PDCER_BQ_MSB        3
`define PDCER_BQ_LSB        2
`define PDCER_SOFT_OFF_BIT  1
`define PDCER_GANG_BIT      0
`define PDCER_REC_MSB       7
`define PDCER_REC_LSB       4
`define PDCER_PLAY_MSB      3
`define PDCER_PLAY_LSB      0

`endif

// [src/pdcer_pkg.sv]
package pdcer_pkg;

  typedef logic [7:0] pdcer_byte_t;

  typedef enum logic [1:0] {
    PDCER_RESP_LINEAR = 2'h0,
    PDCER_RESP_LOW    = 2'h1,
    PDCER_RESP_ULTRA  = 2'h2,
    PDCER_RESP_RSVD   = 2'h3
  } pdcer_resp_e;

  // IIR or fixed cutoffs in fractions of the sample rate
  typedef enum logic [1:0] {
    PDCER_HPF_IIR     = 2'h0,
    PDCER_HPF_FS_20U  = 2'h1,
    PDCER_HPF_FS_250U = 2'h2,
    PDCER_HPF_FS_2M   = 2'h3
  } pdcer_hpf_e;

  typedef struct packed {
    pdcer_resp_e response;
    pdcer_hpf_e  highpass;
    logic [1:0]  biquads;
    logic        soft_step_off;
    logic        volume_shared;
  } pdcer_path_s;

  // Index 1 is channel 1, the most significant bit
  typedef struct packed {
    logic [1:4] record_on;
    logic [1:4] playback_on;
  } pdcer_chan_s;

  typedef pdcer_byte_t [1:4] pdcer_vols_t;

  // Count of stages to per-stage enables
  function automatic logic [2:0] pdcer_bq_stages(input logic [1:0] count);
    logic [2:0] en;
    en = 3'h0;
    case (count)
      2'h1:    en = 3'h1;
      2'h2:    en = 3'h3;
      2'h3:    en = 3'h7;
      default: en = 3'h0;
    endcase
    return en;
  endfunction

endpackage

// [src/pdcer_vol_route.sv]
module pdcer_vol_route
  import pdcer_pkg::*;
(
  input  wire logic        clock_i,     // System clock
  input  wire logic        reset_n_i,   // Sync reset, active low
  input  wire logic        clk_en_i,    // Freezes state when low
  input  wire logic        shared_i,    // Gang all channels to channel 1
  input  wire logic [1:4]  active_i,    // Playback channel enables
  input  wire pdcer_vols_t vol_i,       // Per-channel volume settings
  output pdcer_vols_t      vol_o,       // Volume applied per channel
  output logic [1:4]       vol_valid_o  // Channel active and volume applied
);

  pdcer_vols_t vol_ff;
  pdcer_vols_t nxt_vol;
  logic [1:4]  valid_ff;
  logic [1:4]  nxt_valid;

  always_comb begin
    nxt_vol   = vol_ff;
    nxt_valid = valid_ff;
    for (int ch = 1; ch <= 4; ch++) begin
      nxt_vol[ch] = shared_i ? vol_i[1] : vol_i[ch];
    end
    nxt_valid = active_i;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      vol_ff   <= '0;
      valid_ff <= '0;
    end else if (clk_en_i) begin
      vol_ff   <= nxt_vol;
      valid_ff <= nxt_valid;
    end
  end

  assign vol_o       = vol_ff;
  assign vol_valid_o = valid_ff;

  chk_gang_route: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    reset_n_i && clk_en_i && shared_i
      |=> vol_o[4] == $past(vol_i[1]) && vol_o[2] == $past(vol_i[1]))
    else $error("Ganged volume not taken from channel 1");

  chk_own_volume: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    reset_n_i && clk_en_i && !shared_i
      |=> vol_o[3] == $past(vol_i[3]) && vol_o[4] == $past(vol_i[4]))
    else $error("Channel volume not its own setting");

  chk_valid_track: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    reset_n_i && clk_en_i |=> vol_valid_o == $past(active_i))
    else $error("Active channel flags not tracking enables");

endmodule

// [tb/tb_top.sv]
module tb_top
  import pdcer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock_i;
  logic        reset_n_i;
  logic        clk_en_i;
  logic [7:0]  reg_addr_i;
  logic        reg_wr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_rd_i;
  pdcer_vols_t vol_i;
  logic [7:0]  reg_rdata_o;
  logic        reg_rvalid_o;
  pdcer_path_s path_cfg_o;
  pdcer_chan_s chan_en_o;
  logic [2:0]  biquad_stage_en_o;
  logic        soft_step_on_o;
  logic        resp_reserved_o;
  pdcer_vols_t vol_o;
  logic [1:4]  vol_valid_o;
  int          fail_count;
  int          checked;
  int          cycles;
  logic [2:0]  stages [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [7:0]  chans [4] = '{8'h5a, 8'ha5, 8'h00, 8'hff};

  pdcer_regs u_pdcer_regs (
    .clock_i           (clock_i),
    .reset_n_i         (reset_n_i),
    .clk_en_i          (clk_en_i),
    .reg_addr_i        (reg_addr_i),
    .reg_wr_i          (reg_wr_i),
    .reg_wdata_i       (reg_wdata_i),
    .reg_rd_i          (reg_rd_i),
    .vol_i             (vol_i),
    .reg_rdata_o       (reg_rdata_o),
    .reg_rvalid_o      (reg_rvalid_o),
    .path_cfg_o        (path_cfg_o),
    .chan_en_o         (chan_en_o),
    .biquad_stage_en_o (biquad_stage_en_o),
    .soft_step_on_o    (soft_step_on_o),
    .resp_reserved_o   (resp_reserved_o),
    .vol_o             (vol_o),
    .vol_valid_o       (vol_valid_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Strobe for one cycle, then look just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rvalid", 32'h1, 32'(reg_rvalid_o));
    chk("rdata", 32'(exp), 32'(reg_rdata_o));
  endtask

  task automatic chk_reset;
    chk("path reset", 32'h18, 32'(path_cfg_o));
    chk("chan reset", 32'hcc, 32'(chan_en_o));
    chk("stages reset", 32'h3, 32'(biquad_stage_en_o));
    chk("soft reset", 32'h1, 32'(soft_step_on_o));
    chk("rsvd reset", 32'h0, 32'(resp_reserved_o));
    chk("rdata reset", 32'h0, 32'(reg_rdata_o));
    chk("rvalid reset", 32'h0, 32'(reg_rvalid_o));
    chk("vol reset", 32'h0, 32'(vol_o));
    chk("vol valid reset", 32'h0, 32'(vol_valid_o));
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    logic [7:0] v;
    reset_n_i   = 1'b0;
    clk_en_i    = 1'b1;
    reg_addr_i  = 8'h00;
    reg_wr_i    = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i    = 1'b0;
    vol_i       = {8'h11, 8'h22, 8'h33, 8'h44};
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1;
    chk_reset();
    rd(8'h73, 8'h18);
    rd(8'h76, 8'hcc);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = {2'(i), 2'(i), 2'(i), i[0], i[1]};
      wr(8'h73, v);
      chk("path", 32'(v), 32'(path_cfg_o));
      chk("stages", 32'(stages[i]), 32'(biquad_stage_en_o));
      chk("soft", 32'(!i[0]), 32'(soft_step_on_o));
      chk("rsvd", 32'(i == 3), 32'(resp_reserved_o));
      rd(8'h73, v);
    end
    $display("test path fields done");
    foreach (chans[i]) begin
      wr(8'h76, chans[i]);
      chk("record", 32'(chans[i][7:4]), 32'(chan_en_o.record_on));
      chk("playback", 32'(chans[i][3:0]), 32'(chan_en_o.playback_on));
      rd(8'h76, chans[i]);
    end
    $display("test channel enables done");
    wr(8'h76, 8'h06);
    wr(8'h73, 8'h00);
    @(posedge clock_i);
    #1;
    chk("own vol", {8'h11, 8'h22, 8'h33, 8'h44}, 32'(vol_o));
    chk("vol valid", 32'h6, 32'(vol_valid_o));
    wr(8'h73, 8'h01);
    @(posedge clock_i);
    #1;
    chk("gang vol", {4{8'h11}}, 32'(vol_o));
    chk("gang valid", 32'h6, 32'(vol_valid_o));
    $display("test volume done");
    wr(8'h74, 8'hff);
    chk("no alias", 32'h01, 32'(path_cfg_o));
    rd(8'h74, 8'h00);
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    wr(8'h73, 8'h55);
    chk("frozen", 32'h01, 32'(path_cfg_o));
    @(posedge clock_i);
    clk_en_i    <= 1'b1;
    reg_rd_i    <= 1'b1;
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= 8'h76;
    reg_wdata_i <= 8'h3c;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    reg_wr_i <= 1'b0;
    #1;
    chk("old read", 32'h06, 32'(reg_rdata_o));
    chk("new chan", 32'h3c, 32'(chan_en_o));
    $display("test refusals done");
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1;
    chk_reset();
    $display("test second reset done");
    conclude();
  end
endmodule
